/* File: ced_top.sv */
`timescale 1ns/10ps
module ced_top
  import ced_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        CMP_RAW_I,
  input  wire logic        T1_OVF_I,
  input  wire logic        IDLE_I,
  input  wire logic        PDOWN_I,
  output logic             CMP_OUT_O,
  output logic             IRQ_O,
  output logic             WAKE_O
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  ced_mode_t  mode_ff;
  logic       on_ff;
  logic       idle_run_ff;
  logic       flag_ff;
  logic [7:0] ie_ff;
  logic [7:0] stat_ff;
  logic       pready_ff;
  logic       pslverr_ff;
  logic [31:0] prdata_ff;

  // ==========================================================================
  // APB slave: one wait state, answer in the second access cycle
  // ==========================================================================
  logic acc;
  logic commit;
  logic wr;
  logic rd;
  logic sel_ctrl;
  logic sel_ie;
  logic sel_stat;
  logic mapped;
  logic [31:0] nxt_prdata;

  assign acc      = PSEL_I & PENABLE_I & ~pready_ff;
  assign commit   = PSEL_I & PENABLE_I & pready_ff;
  assign wr       = commit & PWRITE_I;
  assign rd       = commit & ~PWRITE_I;
  assign sel_ctrl = (PADDR_I == CTRL_ADDR);
  assign sel_ie   = (PADDR_I == IE_ADDR);
  assign sel_stat = (PADDR_I == STAT_ADDR);
  assign mapped   = sel_ctrl | sel_ie | sel_stat;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (sel_ctrl) begin
      nxt_prdata[IDLE_RUN_BIT]      = idle_run_ff;
      nxt_prdata[FLAG_BIT]          = flag_ff;
      nxt_prdata[ON_BIT]            = on_ff;
      nxt_prdata[MODE_MSB:MODE_LSB] = mode_ff;
    end else if (sel_ie) begin
      nxt_prdata[7:0] = ie_ff;
    end else if (sel_stat) begin
      nxt_prdata[7:0] = stat_ff;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (CE_I) begin
      pready_ff  <= acc;
      pslverr_ff <= acc & ~mapped;
      if (acc) begin
        prdata_ff <= PWRITE_I ? 32'h0000_0000 : nxt_prdata;
      end
    end
  end

  assign PREADY_O  = pready_ff;
  assign PSLVERR_O = pslverr_ff;
  assign PRDATA_O  = prdata_ff;

  // ==========================================================================
  // Comparator sampling and gating
  // ==========================================================================
  logic cmp_sync;
  logic active;
  logic cmp_eff;
  logic prev_ff;
  logic rise;
  logic fall;

  // Analog front end resolves positive > negative to a one; async, so synced
  ced_sync2 #(
    .W (1)
  ) u_cmp_sync (
    .clk_i  (MCLK_I),
    .srst_i (SRST_I),
    .ce_i   (CE_I),
    .d_i    (CMP_RAW_I),
    .q_o    (cmp_sync)
  );

  assign active  = on_ff & ~PDOWN_I & (~IDLE_I | idle_run_ff);
  assign cmp_eff = cmp_sync & active;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      prev_ff <= 1'b0;
    end else if (CE_I) begin
      prev_ff <= cmp_eff;
    end
  end

  assign rise = cmp_eff & ~prev_ff;
  assign fall = ~cmp_eff & prev_ff;

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  logic plain_hit;
  logic db_start;
  logic is_db;

  always_comb begin
    plain_hit = 1'b0;
    db_start  = 1'b0;
    is_db     = 1'b0;
    unique case (mode_ff)
      MODE_LOW:     plain_hit = ~cmp_eff;
      MODE_RISE:    plain_hit = rise;
      MODE_TOG_DB:  begin
        is_db    = 1'b1;
        db_start = rise | fall;
      end
      MODE_RISE_DB: begin
        is_db    = 1'b1;
        db_start = rise;
      end
      MODE_FALL:    plain_hit = fall;
      MODE_TOG:     plain_hit = rise | fall;
      MODE_FALL_DB: begin
        is_db    = 1'b1;
        db_start = fall;
      end
      MODE_HIGH:    plain_hit = cmp_eff;
    endcase
  end

  // ==========================================================================
  // Debounce sequencer
  // ==========================================================================
  ced_state_t state_ff;
  ced_state_t nxt_state;
  logic       expect_ff;
  logic       ovf_done;
  logic       start_wait;
  logic       db_ok;
  logic       db_rej;

  // Overflow period itself is software's to tune; only the count lives here
  ced_ovf_wait u_ovf_wait (
    .clk_i   (MCLK_I),
    .srst_i  (SRST_I),
    .ce_i    (CE_I),
    .start_i (start_wait),
    .ovf_i   (T1_OVF_I),
    .done_o  (ovf_done)
  );

  always_comb begin
    nxt_state  = state_ff;
    start_wait = 1'b0;
    db_ok      = 1'b0;
    db_rej     = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (active && db_start) begin
          nxt_state  = ST_WAIT;
          start_wait = 1'b1;
        end
      end
      ST_WAIT: begin
        // Disabling or leaving a debounced mode drops the pending event
        if (!active || !is_db) begin
          nxt_state = ST_IDLE;
        end else if (ovf_done) begin
          nxt_state = ST_IDLE;
          db_ok     = (cmp_eff == expect_ff);
          db_rej    = (cmp_eff != expect_ff);
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      state_ff  <= ST_IDLE;
      expect_ff <= 1'b0;
    end else if (CE_I) begin
      state_ff <= nxt_state;
      // Expected level captured once; later edges never restart the wait
      if (start_wait) begin
        expect_ff <= cmp_eff;
      end
    end
  end

  // ==========================================================================
  // Control register and flag
  // ==========================================================================
  logic ev_set;

  assign ev_set = (active & plain_hit) | db_ok;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      mode_ff     <= ced_mode_t'(CTRL_RST[MODE_MSB:MODE_LSB]);
      on_ff       <= CTRL_RST[ON_BIT];
      idle_run_ff <= CTRL_RST[IDLE_RUN_BIT];
    end else if (CE_I && wr && sel_ctrl) begin
      mode_ff     <= ced_mode_t'(PWDATA_I[MODE_MSB:MODE_LSB]);
      on_ff       <= PWDATA_I[ON_BIT];
      idle_run_ff <= PWDATA_I[IDLE_RUN_BIT];
    end
  end

  // Writing zero clears, writing one keeps; an event in the same cycle wins
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      flag_ff <= CTRL_RST[FLAG_BIT];
    end else if (CE_I) begin
      if (ev_set) begin
        flag_ff <= 1'b1;
      end else if (wr && sel_ctrl && !PWDATA_I[FLAG_BIT]) begin
        flag_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupt enable, sticky status, interrupt and wake outputs
  // ==========================================================================
  logic [7:0] stat_set;
  logic [7:0] stat_clr;

  always_comb begin
    stat_set             = 8'h00;
    stat_set[CMP_IE_BIT] = ev_set;
    stat_set[REJ_IE_BIT] = db_rej;
  end

  // Read clears only the bits the master actually saw
  assign stat_clr = (rd && sel_stat) ? prdata_ff[7:0] : 8'h00;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      ie_ff   <= IE_RST;
      stat_ff <= STAT_RST;
    end else if (CE_I) begin
      if (wr && sel_ie) begin
        ie_ff <= PWDATA_I[7:0] & IE_USED_MASK;
      end
      stat_ff <= (stat_ff & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      IRQ_O     <= 1'b0;
      WAKE_O    <= 1'b0;
      CMP_OUT_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_O     <= (flag_ff & ie_ff[CMP_IE_BIT])
                 | (stat_ff[REJ_IE_BIT] & ie_ff[REJ_IE_BIT]);
      WAKE_O    <= ev_set & IDLE_I & idle_run_ff & ie_ff[CMP_IE_BIT];
      CMP_OUT_O <= cmp_eff;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  property p_off_low;
    CE_I && !on_ff |=> !CMP_OUT_O;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output not low while off");

  property p_pdown_off;
    CE_I && PDOWN_I |=> !CMP_OUT_O && !WAKE_O;
  endproperty
  a_pdown_off: assert property (p_pdown_off) else $error("active in power-down");

  property p_idle_off;
    CE_I && IDLE_I && !idle_run_ff && !flag_ff && !(wr && sel_ctrl) |=> !flag_ff;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("flag set in idle without run");

  property p_flag_sticky;
    flag_ff && !(wr && sel_ctrl) |=> flag_ff;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("hardware cleared flag");

  property p_no_set_off;
    CE_I && !on_ff && !flag_ff |=> !flag_ff;
  endproperty
  a_no_set_off: assert property (p_no_set_off) else $error("flag set while off");

  property p_rise_sets;
    CE_I && active && mode_ff == MODE_RISE && rise |=> flag_ff ##1 (IRQ_O || !ie_ff[CMP_IE_BIT]);
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge missed");

  property p_irq_follows;
    CE_I && flag_ff && ie_ff[CMP_IE_BIT] |=> IRQ_O;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

  property p_irq_blocked;
    CE_I && !ie_ff[CMP_IE_BIT] && !(stat_ff[REJ_IE_BIT] && ie_ff[REJ_IE_BIT]) |=> !IRQ_O;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) else $error("irq while disabled");

  property p_wait_holds;
    CE_I && state_ff == ST_WAIT && !ovf_done && active && is_db |=> state_ff == ST_WAIT;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("wait left early");

  property p_db_needs_ovf;
    CE_I && state_ff == ST_IDLE && start_wait |=> !ovf_done;
  endproperty
  a_db_needs_ovf: assert property (p_db_needs_ovf) else $error("wait began done");

  property p_reject;
    CE_I && db_rej && !flag_ff && !(active && plain_hit) |=> !flag_ff && stat_ff[REJ_IE_BIT];
  endproperty
  a_reject: assert property (p_reject) else $error("rejected event set flag");

  property p_wake;
    CE_I && ev_set && IDLE_I && idle_run_ff && ie_ff[CMP_IE_BIT] |=> WAKE_O;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from idle");

  c_db_ok:   cover property (CE_I && db_ok);
  c_db_rej:  cover property (CE_I && db_rej);
  c_wake:    cover property (WAKE_O);
  c_rd_stat: cover property (rd && sel_stat && prdata_ff[CMP_IE_BIT]);

endmodule

/* File: ced_pkg.sv */
package ced_pkg;

  // ==========================================================================
  // Register map (index as printed, byte address is four times the index)
  // ==========================================================================
  localparam logic [11:0] CTRL_IDX      = 12'h097;
  localparam logic [11:0] CTRL_ADDR     = CTRL_IDX << 2;
  localparam logic [11:0] IE_IDX        = 12'h0A8;
  localparam logic [11:0] IE_ADDR       = IE_IDX << 2;
  localparam logic [11:0] STAT_IDX      = 12'h0A9;
  localparam logic [11:0] STAT_ADDR     = STAT_IDX << 2;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned IDLE_RUN_BIT  = 5;
  localparam int unsigned FLAG_BIT      = 4;
  localparam int unsigned ON_BIT        = 3;
  localparam int unsigned MODE_MSB      = 2;
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned CMP_IE_BIT    = 6;
  localparam int unsigned REJ_IE_BIT    = 0;

  // ==========================================================================
  // Reset values and counts
  // ==========================================================================
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  IE_RST        = 8'h00;
  localparam logic [7:0]  STAT_RST      = 8'h00;
  localparam logic [7:0]  IE_USED_MASK  = 8'h41;
  localparam logic [1:0]  OVF_NEEDED    = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    MODE_LOW     = 3'h0,
    MODE_RISE    = 3'h1,
    MODE_TOG_DB  = 3'h2,
    MODE_RISE_DB = 3'h3,
    MODE_FALL    = 3'h4,
    MODE_TOG     = 3'h5,
    MODE_FALL_DB = 3'h6,
    MODE_HIGH    = 3'h7
  } ced_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } ced_state_t;

endpackage

/* File: ced_sync2.sv */
`timescale 1ns/10ps
module ced_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else if (ce_i) begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule

/* File: ced_ovf_wait.sv */
`timescale 1ns/10ps
module ced_ovf_wait
  import ced_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic start_i,
  input  wire logic ovf_i,
  output logic      done_o
);
  logic [1:0] cnt_ff;

  // Overflow in the start cycle is not counted: the wait is at least one period
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= 2'h0;
    end else if (ce_i) begin
      if (start_i) begin
        cnt_ff <= 2'h0;
      end else if (ovf_i && cnt_ff != OVF_NEEDED) begin
        cnt_ff <= cnt_ff + 2'h1;
      end
    end
  end

  assign done_o = (cnt_ff == OVF_NEEDED);
endmodule

/* File: ced_partner_model.sv */
`timescale 1ns/10ps
module ced_partner_model (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  int        pos_i,
  input  int        neg_i,
  input  int        period_i,
  output logic      cmp_o,
  output logic      ovf_o
);
  int cnt;

  // ==========================================
  // Analog decision
  assign cmp_o = (pos_i > neg_i);

  // ==========================================
  // Timer overflow
  // Free running, so edges land anywhere in the period
  always_ff @(posedge clk_i) begin
    if (srst_i || cnt >= period_i - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    ovf_o <= !srst_i && (cnt == period_i - 1);
  end
endmodule

/* File: ced_top_bench.sv */
`timescale 1ns/10ps
module ced_top_bench;
  import ced_pkg::*;
  localparam int P = 16;
  logic        clk, srst, psel, pen, pwr, pready, pslverr;
  logic        cmp, ovf, idle, pdown, cmp_out, irq, wake, e, fl, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  m;
  logic [7:0]  modes [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h07};
  logic [7:0]  dbm [3]   = '{8'h03, 8'h06, 8'h02};
  int          pos, n_fail, num_checks, n_wake, seed, d, a, b, s, g, k, ie;

  ced_top dut_u (.MCLK_I(clk), .SRST_I(srst), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CMP_RAW_I(cmp),
    .T1_OVF_I(ovf), .IDLE_I(idle), .PDOWN_I(pdown), .CMP_OUT_O(cmp_out),
    .IRQ_O(irq), .WAKE_O(wake));
  ced_partner_model part_u (.clk_i(clk), .srst_i(srst), .pos_i(pos), .neg_i(500),
    .period_i(P), .cmp_o(cmp), .ovf_o(ovf));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (wake === 1'b1) n_wake++;

  // ==========================================
  // Reporting
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask

  // ==========================================
  // Bus and stimulus
  // One idle edge first, so a release never meets the next setup
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] v);
    apb(1'b1, ad, {24'h0, v});
  endtask
  task automatic rd(input logic [11:0] ad, input logic [7:0] v);
    apb(1'b0, ad, 32'h0);
    chk_reg(q, {24'h0, v});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic lvl(input logic v);
    pos <= v ? 510 : 490;
  endtask

  // Reference for the plain modes: level modes also see the level before the change
  function automatic logic exp_flag(input int md, input int x, input int y);
    case (md)
      0: return !(x && y);
      1: return !x && y;
      4: return x && !y;
      5: return x != y;
      default: return x || y;
    endcase
  endfunction

  // ==========================================
  // Main sequence
  initial begin
    seed = 32'h0585BE4C;
    {srst, psel, pen, pwr, idle, pdown} = 6'h20;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    pos = 490;
    {n_fail, num_checks, n_wake} = {32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(CTRL_ADDR, CTRL_RST);
    rd(IE_ADDR, IE_RST);
    rd(STAT_ADDR, STAT_RST);
    rd(12'h000, 8'h00);
    chk_bit(e, 1'b1);
    wr(IE_ADDR, 8'hFF);
    rd(IE_ADDR, IE_USED_MASK);
    wr(CTRL_ADDR, 8'hE7);
    rd(CTRL_ADDR, 8'h27);
    wr(CTRL_ADDR, 8'h08);
    $display("registers done");
    foreach (modes[i]) begin
      for (k = 0; k < 6; k++) begin
        m  = modes[i];
        a  = $random(seed) & 1;
        b  = $random(seed) & 1;
        ie = $random(seed) & 1;
        fl = exp_flag(m, a, b);
        wr(IE_ADDR, ie[0] ? 8'h40 : 8'h00);
        // Mode first: an event of the old mode would beat the clear below
        wr(CTRL_ADDR, 8'h08 | m);
        lvl(a[0]);
        tick(6);
        wr(CTRL_ADDR, 8'h08 | m);
        lvl(b[0]);
        tick(6);
        chk_bit(cmp_out, b[0]);
        chk_bit(irq, fl & ie[0]);
        rd(CTRL_ADDR, 8'h08 | m | {3'h0, fl, 4'h0});
      end
    end
    $display("plain modes done");
    for (k = 0; k < 9; k++) begin
      m = dbm[k % 3];
      g = k / 3;
      s = (m == 8'h06) ? 1 : (m == 8'h03) ? 0 : $random(seed) & 1;
      wr(CTRL_ADDR, 8'h0D);
      lvl(s[0]);
      wr(IE_ADDR, 8'h41);
      wr(CTRL_ADDR, 8'h08 | m);
      apb(1'b0, STAT_ADDR, 32'h0);
      tick(2);
      lvl(!s[0]);
      d = 0;
      // Bounce back in the later two groups, and for the last group settle again later in the wait
      while (irq !== 1'b1 && d < 3 * P + 20) begin
        @(posedge clk);
        d++;
        if (g > 0 && d == 3) lvl(s[0]);
        if (g == 2 && d == 10) lvl(!s[0]);
      end
      if (irq !== 1'b1) begin
        n_fail++;
        give_verdict();
      end
      chk_bit(d >= P && d <= 2 * P + 8, 1'b1);
      rd(CTRL_ADDR, 8'h08 | m | (g == 1 ? 8'h00 : 8'h10));
      rd(STAT_ADDR, g == 1 ? 8'h01 : 8'h40);
    end
    $display("debounced modes done");
    wr(IE_ADDR, 8'h40);
    lvl(1'b1);
    wr(CTRL_ADDR, 8'h07);
    tick(6);
    chk_bit(cmp_out, 1'b0);
    rd(CTRL_ADDR, 8'h07);
    pdown <= 1'b1;
    wr(CTRL_ADDR, 8'h2F);
    tick(6);
    chk_bit(cmp_out, 1'b0);
    rd(CTRL_ADDR, 8'h2F);
    wr(CTRL_ADDR, 8'h0F);
    pdown <= 1'b0;
    idle  <= 1'b1;
    tick(6);
    rd(CTRL_ADDR, 8'h0F);
    chk_bit(n_wake == 0, 1'b1);
    wr(CTRL_ADDR, 8'h2F);
    tick(6);
    rd(CTRL_ADDR, 8'h3F);
    chk_bit(n_wake != 0, 1'b1);
    chk_bit(irq, 1'b1);
    idle <= 1'b0;
    $display("power gating done");
    // Second write clears: the first loses to the high-level event
    wr(CTRL_ADDR, 8'h08);
    wr(CTRL_ADDR, 8'h08);
    tick(2);
    ce <= 1'b0;
    lvl(1'b0);
    tick(8);
    chk_bit(cmp_out, 1'b1);
    chk_bit(irq, 1'b0);
    ce <= 1'b1;
    tick(6);
    chk_bit(cmp_out, 1'b0);
    chk_bit(irq, 1'b1);
    $display("clock enable done");
    give_verdict();
  end
endmodule
